// ### sipol_consts.svh
// Constants for the serial-in parallel-out latch.
`ifndef SIPOL_CONSTS_SVH
`define SIPOL_CONSTS_SVH
`define SIPOL_WIDTH 8
`define SIPOL_CLEAR_VALUE 8'h00
`define SIPOL_BUF_DEPTH 2
`endif

// ### sipol_pkg.sv
// Types shared by the serial-in parallel-out latch.
`include "sipol_consts.svh"
package sipol_pkg;
	typedef logic [`SIPOL_WIDTH-1:0] sipol_word_t;
endpackage : sipol_pkg

// ### sipol_buf.sv
// Two-entry valid/ready buffer for stored words.
`timescale 1ns/10ps
`include "sipol_consts.svh"
module sipol_buf #(
	parameter int WIDTH = `SIPOL_WIDTH
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Write side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Read side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_ff [2];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic [1:0] count_ff;
	logic do_wr;
	logic do_rd;

	assign in_ready = (count_ff != 2'h2);
	assign out_valid = (count_ff != 2'h0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
		end else if (do_wr) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff <= 2'h0;
		end else begin
			if (do_wr) begin
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (do_rd) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
			count_ff <= count_ff + {1'b0, do_wr} - {1'b0, do_rd};
		end
	end
endmodule : sipol_buf

// ### sipol_latch.sv
// Serial-in shift register with storage register and parallel outputs.
`timescale 1ns/10ps
`include "sipol_consts.svh"
//
// Summary of operation
// - Eight-stage shift register feeds a separate eight-bit storage register.
// - Only rising edges of shift clock and storage clock act.
// - With clocks tied, storage gets the pre-edge shift contents, one behind.
// - Storage clear low forces storage register to zero regardless of all else.
// - Shift clear low forces all shift stages to zero regardless of all else.
// - Shift clock rise loads serial data into stage one and shifts onward.
// - Storage clock rise with both clears high copies shift stages to storage.
// - Simultaneous rises transfer old shift contents and shift in new bit.
// - Shift register holds when its clock is steady or falling.
// - Storage register holds when its clock is steady or falling.
// - Controller clears both registers before trusting outputs after power-up.
// - Parallel outputs keep stored pattern while new data shifts in.
// - Both clears act when low; high lets the register clock.
// - A dedicated serial output feeds the next device in a chain.
module sipol_latch #(
	parameter int WIDTH = `SIPOL_WIDTH
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Controller inputs.
	input wire logic serial_data_in,
	input wire logic shift_clock,
	input wire logic shift_clear_n,
	input wire logic storage_clock,
	input wire logic storage_clear_n,
	// Parallel and cascade outputs.
	output sipol_pkg::sipol_word_t par_out_ff,
	output logic serial_out_ff,
	// Stream of stored words.
	output logic word_valid_ff,
	output sipol_pkg::sipol_word_t word_data_ff,
	input wire logic word_ready,
	output logic word_ready_in_ff
);
	import sipol_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic rst_meta_ff;
	logic rst_n_ff;
	logic shift_clock_d_ff;
	logic storage_clock_d_ff;
	logic shift_rise;
	logic store_rise;
	sipol_word_t shift_ff;
	sipol_word_t nxt_shift;
	logic buf_out_valid;
	sipol_word_t buf_out_data;
	logic buf_in_ready;

	// Reset release is synchronised so that all state leaves reset together.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge detection on the controller clocks.
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			shift_clock_d_ff <= 1'b0;
			storage_clock_d_ff <= 1'b0;
		end else begin
			shift_clock_d_ff <= shift_clock;
			storage_clock_d_ff <= storage_clock;
		end
	end

	assign shift_rise = shift_clock && !shift_clock_d_ff;
	assign store_rise = storage_clock && !storage_clock_d_ff;

	function automatic sipol_word_t shift_in(input sipol_word_t cur, input logic bit_in);
		shift_in = {cur[`SIPOL_WIDTH-2:0], bit_in};
	endfunction : shift_in

	assign nxt_shift = shift_in(shift_ff, serial_data_in);

	////////////////////////////////////////////////////////////////////////
	// Shift register.
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			shift_ff <= `SIPOL_CLEAR_VALUE;
		end else if (!shift_clear_n) begin
			shift_ff <= `SIPOL_CLEAR_VALUE;
		end else if (shift_rise) begin
			shift_ff <= nxt_shift;
		end
	end

	assign serial_out_ff = shift_ff[`SIPOL_WIDTH-1];

	////////////////////////////////////////////////////////////////////////
	// Storage register; reads shift_ff before this edge's update.
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			par_out_ff <= `SIPOL_CLEAR_VALUE;
		end else if (!storage_clear_n) begin
			par_out_ff <= `SIPOL_CLEAR_VALUE;
		end else if (store_rise && shift_clear_n) begin
			par_out_ff <= shift_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Each stored word is also offered on the stream through a buffer; a word stored while the buffer is full is not offered.
	sipol_buf #(.WIDTH(WIDTH)) u_buf (
		.clk(clk),
		.rst_n(rst_n_ff),
		.in_valid(store_rise && shift_clear_n && storage_clear_n),
		.in_ready(buf_in_ready),
		.in_data(shift_ff),
		.out_valid(buf_out_valid),
		.out_ready(word_ready || !word_valid_ff),
		.out_data(buf_out_data)
	);

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			word_valid_ff <= 1'b0;
			word_data_ff <= `SIPOL_CLEAR_VALUE;
			word_ready_in_ff <= 1'b0;
		end else begin
			word_ready_in_ff <= buf_in_ready;
			if (word_ready || !word_valid_ff) begin
				word_valid_ff <= buf_out_valid;
				word_data_ff <= buf_out_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_shift_clear;
		@(posedge clk) disable iff (!rst_n_ff) !shift_clear_n |=> shift_ff == 8'h00;
	endproperty
	a_shift_clear: assert property (p_shift_clear) else $error("shift not cleared");

	property p_store_clear;
		@(posedge clk) disable iff (!rst_n_ff) !storage_clear_n |=> par_out_ff == 8'h00;
	endproperty
	a_store_clear: assert property (p_store_clear) else $error("storage not cleared");

	property p_shift_step;
		@(posedge clk) disable iff (!rst_n_ff)
			shift_clear_n && shift_rise |=> shift_ff == {$past(shift_ff[6:0]), $past(serial_data_in)};
	endproperty
	a_shift_step: assert property (p_shift_step) else $error("bad shift");

	sequence s_both_rise;
		shift_clear_n && storage_clear_n && store_rise;
	endsequence
	property p_transfer;
		@(posedge clk) disable iff (!rst_n_ff) s_both_rise |=> par_out_ff == $past(shift_ff);
	endproperty
	a_transfer: assert property (p_transfer) else $error("bad transfer");

	sequence s_tied_rise;
		s_both_rise ##0 shift_rise;
	endsequence
	property p_tied;
		@(posedge clk) disable iff (!rst_n_ff)
			s_tied_rise |=> par_out_ff == $past(shift_ff) &&
				shift_ff == {$past(shift_ff[6:0]), $past(serial_data_in)};
	endproperty
	a_tied: assert property (p_tied) else $error("storage not one behind");

	property p_shift_hold;
		@(posedge clk) disable iff (!rst_n_ff) shift_clear_n && !shift_rise |=> $stable(shift_ff);
	endproperty
	a_shift_hold: assert property (p_shift_hold) else $error("shift moved");

	property p_store_hold;
		@(posedge clk) disable iff (!rst_n_ff)
			storage_clear_n && !store_rise |=> $stable(par_out_ff);
	endproperty
	a_store_hold: assert property (p_store_hold) else $error("storage moved");

	property p_serial_out;
		@(posedge clk) disable iff (!rst_n_ff)
			shift_clear_n && shift_rise |=> serial_out_ff == $past(shift_ff[6]);
	endproperty
	a_serial_out: assert property (p_serial_out) else $error("serial out wrong");

	sequence s_shift_edge;
		shift_clear_n && $rose(shift_clock);
	endsequence
	property p_shift_edge;
		@(posedge clk) disable iff (!rst_n_ff)
			s_shift_edge |=> shift_ff == {$past(shift_ff[6:0]), $past(serial_data_in)};
	endproperty
	a_shift_edge: assert property (p_shift_edge) else $error("shift edge missed");

	sequence s_store_edge;
		shift_clear_n && storage_clear_n && $rose(storage_clock);
	endsequence
	property p_store_edge;
		@(posedge clk) disable iff (!rst_n_ff) s_store_edge |=> par_out_ff == $past(shift_ff);
	endproperty
	a_store_edge: assert property (p_store_edge) else $error("store edge missed");

	// A storage rise while the shift stages are held clear is ignored.
	property p_store_refused;
		@(posedge clk) disable iff (!rst_n_ff)
			storage_clear_n && !shift_clear_n |=> $stable(par_out_ff);
	endproperty
	a_store_refused: assert property (p_store_refused) else $error("storage moved");

	property p_par_keep;
		@(posedge clk) disable iff (!rst_n_ff)
			storage_clear_n && shift_rise && !store_rise |=> $stable(par_out_ff);
	endproperty
	a_par_keep: assert property (p_par_keep) else $error("outputs moved on shift");

	property p_clear_wins;
		@(posedge clk) disable iff (!rst_n_ff)
			!shift_clear_n && shift_rise |=> shift_ff == 8'h00;
	endproperty
	a_clear_wins: assert property (p_clear_wins) else $error("clock beat clear");

	property p_word_hold;
		@(posedge clk) disable iff (!rst_n_ff)
			word_valid_ff && !word_ready |=> word_valid_ff && $stable(word_data_ff);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("stalled word lost");
endmodule : sipol_latch

// ### sipol_sink.sv
// Stream sink model for the stored words.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module sipol_sink (
	// Clock and stall request.
	input wire logic clk,
	input wire logic stall,
	// Stream handshake.
	output logic word_ready
);
	initial word_ready = 1'b0;
	// Random holds last one cycle at most, so only a stall can fill the buffer.
	always @(posedge clk) begin
		#1 word_ready = !stall && (!word_ready || ($urandom % 2 == 0));
	end
endmodule : sipol_sink

// ### test_serial_in_parallel_out_latch.sv
// Self-checking bench for the serial-in parallel-out latch.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	$display("MISMATCH %s exp %h got %h", nm, e, g); mismatches++; end end
////////////////////////////////////////////////////////////////
module test_serial_in_parallel_out_latch;
	import sipol_pkg::*;
	logic clk = 0, nrst = 0, sdi = 0, sck = 0, scl_n = 0, rck = 0, rcl_n = 0, stall = 0;
	logic sout, wval, wrdy, wfree, sout2;
	sipol_word_t par, wdat, w, sh = 0, st = 0, par2, sh2 = 0, st2 = 0, q[$];
	int mismatches = 0, cmp_count = 0, cyc = 0;
	always #10 clk = ~clk;
	sipol_latch dut (.clk(clk), .nrst(nrst), .serial_data_in(sdi), .shift_clock(sck),
		.shift_clear_n(scl_n), .storage_clock(rck), .storage_clear_n(rcl_n),
		.par_out_ff(par), .serial_out_ff(sout), .word_valid_ff(wval),
		.word_data_ff(wdat), .word_ready(wrdy), .word_ready_in_ff(wfree));
	sipol_sink sink (.clk(clk), .stall(stall), .word_ready(wrdy));
	// A second stage fed from the first one's serial output forms a chain.
	sipol_latch dut_next (.clk(clk), .nrst(nrst), .serial_data_in(sout), .shift_clock(sck),
		.shift_clear_n(scl_n), .storage_clock(rck), .storage_clear_n(rcl_n),
		.par_out_ff(par2), .serial_out_ff(sout2), .word_valid_ff(),
		.word_data_ff(), .word_ready(1'b1), .word_ready_in_ff());
	task results;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			results();
		end
	end
	// Every accepted word must match the oldest store noted by the driver.
	always @(posedge clk) begin
		if (wval === 1'b1 && wrdy === 1'b1) begin
			if (q.size() == 0) begin
				`CHK("stray word", 1'b0, 1'b1)
			end else begin
				w = q.pop_front();
				`CHK("word", w, wdat)
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// One rise of the chosen clocks, a low sample, then a settled check.
	task step(input logic s, input logic r, input logic d);
		sipol_word_t old, old2;
		old = sh;
		old2 = sh2;
		sck = s;
		rck = r;
		sdi = d;
		if (r && scl_n && rcl_n && wfree === 1'b1) q.push_back(old);
		@(posedge clk);
		#1;
		sck = 0;
		rck = 0;
		sdi = ~d;
		if (s && scl_n) sh = {old[6:0], d};
		if (r && scl_n && rcl_n) st = old;
		if (!scl_n) sh = 8'h00;
		if (!rcl_n) st = 8'h00;
		if (s && scl_n) sh2 = {old2[6:0], old[7]};
		if (r && scl_n && rcl_n) st2 = old2;
		if (!scl_n) sh2 = 8'h00;
		if (!rcl_n) st2 = 8'h00;
		repeat (2) @(posedge clk);
		#1;
		`CHK("parallel", st, par)
		`CHK("serial", sh[7], sout)
		`CHK("chain parallel", st2, par2)
		`CHK("chain serial", sh2[7], sout2)
	endtask : step
	////////////////////////////////////////////////////////////////
	initial begin
		sipol_word_t b;
		void'($urandom(50));
		repeat (3) @(posedge clk);
		#1 nrst = 1;
		repeat (3) @(posedge clk);
		#1;
		step(1, 1, 1);
		scl_n = 1;
		rcl_n = 1;
		`CHK("ready", 1'b1, wfree)
		repeat (4) begin
			b = 8'($urandom);
			for (int i = 7; i >= 0; i--) step(1, 0, b[i]);
			step(0, 1, 0);
		end
		repeat (3) step(1, 1, 1'($urandom));
		rcl_n = 0;
		step(1, 1, 1);
		rcl_n = 1;
		step(0, 1, 0);
		scl_n = 0;
		step(1, 1, 1);
		scl_n = 1;
		step(1, 0, 1);
		step(0, 1, 0);
		stall = 1;
		repeat (4) step(1, 1, 1);
		`CHK("buffer full", 1'b0, wfree)
		stall = 0;
		repeat (10) @(posedge clk);
		#1;
		`CHK("words left", 0, q.size())
		results();
	end
endmodule : test_serial_in_parallel_out_latch
